// [pim_match.v]
// Pin synchroniser and masked pattern compare for one 8-bit port
`timescale 1ns/10ps
`include "pim_regs.vh"

module pim_match (
  clk,
  rst_n,
  ce,
  pin_raw,
  analog_sel,
  cmp_mask,
  cmp_value,
  pin_level,
  mismatch
);
  input wire clk; // System clock
  input wire rst_n; // Asynchronous reset, active low
  input wire ce; // Clock enable, freezes state while low
  input wire [7:0] pin_raw; // Pin levels straight from the pads
  input wire [7:0] analog_sel; // 0 marks an analog pin
  input wire [7:0] cmp_mask; // Compare mask
  input wire [7:0] cmp_value; // Compare value
  output wire [7:0] pin_level; // Synchronised, receiver-gated level
  output reg mismatch; // Registered match event level

  reg [7:0] sync1_ff; // First stage, read only by second stage
  reg [7:0] sync2_ff; // Second stage
  wire [7:0] nxt_sync1;
  wire [7:0] nxt_sync2;
  wire nxt_mismatch;

  // ---------------------------------------------------------------------------
  // Two-flop synchroniser
  // ---------------------------------------------------------------------------
  assign nxt_sync1 = pin_raw;
  assign nxt_sync2 = sync1_ff;

  // Pins are sampled every enabled clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else if (ce) begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // Analog pins have their receiver off and read as low
  assign pin_level = sync2_ff & analog_sel;

  // ---------------------------------------------------------------------------
  // Masked compare
  // ---------------------------------------------------------------------------
  // Unmasked pins drop out, masked pins meet their value bit
  assign nxt_mismatch = ((pin_level & cmp_mask) != (cmp_value & cmp_mask));

  // Level condition refreshed on each enabled clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mismatch <= 1'b0;
    end else if (ce) begin
      mismatch <= nxt_mismatch;
    end
  end
endmodule // pim_match

// [pim_pad_model.sv]
// Pad model: resolves a port's pins from block driver, outside driver and pullup
`timescale 1ns/10ps
module pim_pad_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output wire logic [7:0] pad
);
  logic [7:0] float_ff = 8'h5A; // Undriven, unpulled pins wander each cycle
  // Floating pattern flips every clock
  always @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  // Block driver first, then outside driver, then pullup, else floating
  assign pad = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) |
               (pin_oe_n & ~ext_en & (pullup_en | float_ff));
endmodule // pim_pad_model

// [pim_port_io.v]
// Top of the three-port I/O configuration, data and match block
`timescale 1ns/10ps
`include "pim_regs.vh"

module pim_port_io (
  clk,
  rst_n,
  ce,
  sfr_addr,
  sfr_wr,
  sfr_rd,
  sfr_rmw,
  sfr_wdata,
  sfr_rdata,
  crossbar_enable_bit,
  weak_pullup_disable,
  port_match_irq_enable,
  port0_analog_select,
  port0_drive_type,
  p0_pin_in,
  p0_pin_out,
  p0_pin_oe_n,
  p1_pin_in,
  p1_pin_out,
  p1_pin_oe_n,
  p2_pin_in,
  p2_pin_out,
  p2_pin_oe_n,
  p0_pullup_en,
  p1_pullup_en,
  p2_pullup_en,
  p0_receiver_en,
  p1_receiver_en,
  p2_receiver_en,
  p0_crossbar_skip,
  p1_crossbar_skip,
  p2_crossbar_skip,
  p0_hiz_overdrive,
  port0_match,
  port1_match,
  port_match_irq,
  port_match_wake
);
  input wire clk; // System clock
  input wire rst_n; // Asynchronous reset, active low
  input wire ce; // Clock enable
  input wire [7:0] sfr_addr; // Register address
  input wire sfr_wr; // Write strobe
  input wire sfr_rd; // Read strobe
  input wire sfr_rmw; // Read belongs to a read-modify-write
  input wire [7:0] sfr_wdata; // Write data
  output reg [7:0] sfr_rdata; // Read data, valid the cycle after sfr_rd
  input wire crossbar_enable_bit; // Crossbar enable from its control register
  input wire weak_pullup_disable; // Global weak pullup disable
  input wire port_match_irq_enable; // Port match interrupt enable
  input wire [7:0] port0_analog_select; // Port 0 input mode, held outside
  input wire [7:0] port0_drive_type; // Port 0 output mode, held outside
  input wire [7:0] p0_pin_in; // Port 0 pad levels
  output wire [7:0] p0_pin_out; // Port 0 pad output value
  output wire [7:0] p0_pin_oe_n; // Port 0 driver enable, active low
  input wire [7:0] p1_pin_in; // Port 1 pad levels
  output wire [7:0] p1_pin_out; // Port 1 pad output value
  output wire [7:0] p1_pin_oe_n; // Port 1 driver enable, active low
  input wire [7:0] p2_pin_in; // Port 2 pad levels
  output wire [7:0] p2_pin_out; // Port 2 pad output value
  output wire [7:0] p2_pin_oe_n; // Port 2 driver enable, active low
  output wire [7:0] p0_pullup_en; // Port 0 weak pullup enables
  output wire [7:0] p1_pullup_en; // Port 1 weak pullup enables
  output wire [7:0] p2_pullup_en; // Port 2 weak pullup enables
  output wire [7:0] p0_receiver_en; // Port 0 digital receiver enables
  output wire [7:0] p1_receiver_en; // Port 1 digital receiver enables
  output wire [7:0] p2_receiver_en; // Port 2 digital receiver enables
  output wire [7:0] p0_crossbar_skip; // Port 0 skip flags to the decoder
  output wire [7:0] p1_crossbar_skip; // Port 1 skip flags to the decoder
  output wire [7:0] p2_crossbar_skip; // Port 2 skip flags to the decoder
  output wire [7:0] p0_hiz_overdrive; // Port 0 high-impedance overdrive select
  output wire port0_match; // Port 0 match event level
  output wire port1_match; // Port 1 match event level
  output wire port_match_irq; // Interrupt request level
  output wire port_match_wake; // Oscillator wake-up level

  // ---------------------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------------------
  reg [7:0] port0_data_latch_ff; // Port 0 output latch
  reg [7:0] port1_data_latch_ff; // Port 1 output latch
  reg [7:0] port2_data_latch_ff; // Port 2 output latch
  reg [7:0] port1_drive_type_ff; // Port 1 drive type
  reg port2_drive_type_ff; // Port 2 drive type, only bit 0 exists
  reg [7:0] port0_overdrive_select_ff; // Port 0 overdrive mode
  reg [7:0] port0_compare_mask_ff; // Port 0 compare mask
  reg [7:0] port1_compare_mask_ff; // Port 1 compare mask
  reg [7:0] port0_compare_value_ff; // Port 0 compare value
  reg [7:0] port1_compare_value_ff; // Port 1 compare value
  reg [7:0] port0_crossbar_bypass_ff; // Port 0 skip bits
  reg [7:0] port1_crossbar_bypass_ff; // Port 1 skip bits
  reg [7:0] port2_crossbar_bypass_ff; // Port 2 skip bits
  reg [7:0] port1_analog_select_ff; // Port 1 input mode
  reg [7:0] port2_analog_select_ff; // Port 2 input mode
  reg [7:0] p2_sync1_ff; // Port 2 first sync stage
  reg [7:0] p2_sync2_ff; // Port 2 second sync stage
  reg [7:0] nxt_rdata; // Read mux result

  wire [7:0] p0_level; // Port 0 synchronised level
  wire [7:0] p1_level; // Port 1 synchronised level
  wire [7:0] p2_level; // Port 2 synchronised, gated level
  wire [7:0] p2_drive_full; // Port 2 drive type as seen by the pins
  wire [7:0] nxt_p2_sync1;
  wire [7:0] nxt_p2_sync2;

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Active-low driver enable for one port
  function [7:0] drive_oe_n;
    input [7:0] latch;
    input [7:0] asel;
    input [7:0] push_pull;
    input xbar;
    begin
      // Push-pull drives both levels, open-drain only lows
      // Analog pins never drive, mode bit then ignored
      // Crossbar off keeps every driver off
      drive_oe_n = ~({8{xbar}} & asel & (push_pull | ~latch));
    end
  endfunction

  // Weak pullup for digital pins whose driver is off
  function [7:0] pullup_on;
    input [7:0] latch;
    input [7:0] asel;
    input [7:0] push_pull;
    input xbar;
    input wpd;
    begin
      // Pullup off for analog pins
      pullup_on = {8{~wpd}} & asel & ~({8{xbar}} & (push_pull | ~latch));
    end
  endfunction

  // Port data read: latch for read-modify-write, else the pins
  function [7:0] port_read;
    input [7:0] latch;
    input [7:0] level;
    input rmw;
    begin
      // Latch returned to read-modify-write
      // Live level, analog pins already zero
      port_read = rmw ? latch : level;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Match compare for ports 0 and 1
  // ---------------------------------------------------------------------------
  pim_match u_p0_match (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin_raw(p0_pin_in),
    .analog_sel(port0_analog_select),
    .cmp_mask(port0_compare_mask_ff),
    .cmp_value(port0_compare_value_ff),
    .pin_level(p0_level),
    .mismatch(port0_match)
  );

  pim_match u_p1_match (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin_raw(p1_pin_in),
    .analog_sel(port1_analog_select_ff),
    .cmp_mask(port1_compare_mask_ff),
    .cmp_value(port1_compare_value_ff),
    .pin_level(p1_level),
    .mismatch(port1_match)
  );

  // Either port event wakes the oscillator, and asks for service when the interrupt is enabled
  assign port_match_wake = port0_match | port1_match;
  assign port_match_irq = port_match_wake & port_match_irq_enable;

  // ---------------------------------------------------------------------------
  // Port 2 synchroniser
  // ---------------------------------------------------------------------------
  assign nxt_p2_sync1 = p2_pin_in;
  assign nxt_p2_sync2 = p2_sync1_ff;

  // Two flops, first stage read only by the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p2_sync1_ff <= 8'h00;
      p2_sync2_ff <= 8'h00;
    end else if (ce) begin
      p2_sync1_ff <= nxt_p2_sync1;
      p2_sync2_ff <= nxt_p2_sync2;
    end
  end

  // Receiver off for analog pins
  assign p2_level = p2_sync2_ff & port2_analog_select_ff;

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  // One register per address, written on the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_data_latch_ff <= `PIM_RST_LATCH;
      port1_data_latch_ff <= `PIM_RST_LATCH;
      port2_data_latch_ff <= `PIM_RST_LATCH;
      port1_drive_type_ff <= `PIM_RST_DRIVE;
      port2_drive_type_ff <= 1'b0;
      port0_overdrive_select_ff <= `PIM_RST_OVRDRV;
      port0_compare_mask_ff <= `PIM_RST_MASK;
      port1_compare_mask_ff <= `PIM_RST_MASK;
      port0_compare_value_ff <= `PIM_RST_VALUE;
      port1_compare_value_ff <= `PIM_RST_VALUE;
      port0_crossbar_bypass_ff <= `PIM_RST_BYPASS;
      port1_crossbar_bypass_ff <= `PIM_RST_BYPASS;
      port2_crossbar_bypass_ff <= `PIM_RST_BYPASS;
      port1_analog_select_ff <= `PIM_RST_ANALOG;
      port2_analog_select_ff <= `PIM_RST_ANALOG;
    end else if (ce && sfr_wr) begin
      case (sfr_addr)
        `PIM_ADDR_P0_LATCH: begin
          port0_data_latch_ff <= sfr_wdata;
        end
        `PIM_ADDR_P1_LATCH: begin
          port1_data_latch_ff <= sfr_wdata;
        end
        `PIM_ADDR_P2_LATCH: begin
          port2_data_latch_ff <= sfr_wdata;
        end
        `PIM_ADDR_P1_DRIVE: begin
          port1_drive_type_ff <= sfr_wdata;
        end
        `PIM_ADDR_P2_DRIVE: begin
          // Upper bits read-only, writes dropped
          port2_drive_type_ff <= sfr_wdata[`PIM_P2_DRIVE_WR_BIT];
        end
        `PIM_ADDR_P0_OVRDRV: begin
          port0_overdrive_select_ff <= sfr_wdata;
        end
        `PIM_ADDR_P0_MASK: begin
          port0_compare_mask_ff <= sfr_wdata;
        end
        `PIM_ADDR_P1_MASK: begin
          port1_compare_mask_ff <= sfr_wdata;
        end
        `PIM_ADDR_P0_VALUE: begin
          port0_compare_value_ff <= sfr_wdata;
        end
        `PIM_ADDR_P1_VALUE: begin
          port1_compare_value_ff <= sfr_wdata;
        end
        `PIM_ADDR_P0_BYPASS: begin
          port0_crossbar_bypass_ff <= sfr_wdata;
        end
        `PIM_ADDR_P1_BYPASS: begin
          port1_crossbar_bypass_ff <= sfr_wdata;
        end
        `PIM_ADDR_P2_BYPASS: begin
          port2_crossbar_bypass_ff <= sfr_wdata;
        end
        `PIM_ADDR_P1_ANALOG: begin
          port1_analog_select_ff <= sfr_wdata;
        end
        `PIM_ADDR_P2_ANALOG: begin
          port2_analog_select_ff <= sfr_wdata;
        end
        default: begin
          // Unmapped address, nothing stored
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------------------
  assign p2_drive_full = {7'h00, port2_drive_type_ff};

  // Read multiplexer
  always @* begin
    case (sfr_addr)
      `PIM_ADDR_P0_LATCH: nxt_rdata = port_read(port0_data_latch_ff, p0_level, sfr_rmw);
      `PIM_ADDR_P1_LATCH: nxt_rdata = port_read(port1_data_latch_ff, p1_level, sfr_rmw);
      `PIM_ADDR_P2_LATCH: nxt_rdata = port_read(port2_data_latch_ff, p2_level, sfr_rmw);
      `PIM_ADDR_P1_DRIVE: nxt_rdata = port1_drive_type_ff;
      `PIM_ADDR_P2_DRIVE: nxt_rdata = p2_drive_full;
      `PIM_ADDR_P0_OVRDRV: nxt_rdata = port0_overdrive_select_ff;
      `PIM_ADDR_P0_MASK: nxt_rdata = port0_compare_mask_ff;
      `PIM_ADDR_P1_MASK: nxt_rdata = port1_compare_mask_ff;
      `PIM_ADDR_P0_VALUE: nxt_rdata = port0_compare_value_ff;
      `PIM_ADDR_P1_VALUE: nxt_rdata = port1_compare_value_ff;
      `PIM_ADDR_P0_BYPASS: nxt_rdata = port0_crossbar_bypass_ff;
      `PIM_ADDR_P1_BYPASS: nxt_rdata = port1_crossbar_bypass_ff;
      `PIM_ADDR_P2_BYPASS: nxt_rdata = port2_crossbar_bypass_ff;
      `PIM_ADDR_P1_ANALOG: nxt_rdata = port1_analog_select_ff;
      `PIM_ADDR_P2_ANALOG: nxt_rdata = port2_analog_select_ff;
      default: nxt_rdata = `PIM_UNMAPPED_READ;
    endcase
  end

  // Read data held until the next read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= `PIM_RST_RDATA;
    end else if (ce && sfr_rd) begin
      sfr_rdata <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drive, pullups and receivers
  // ---------------------------------------------------------------------------
  // Output value straight from the latches
  assign p0_pin_out = port0_data_latch_ff;
  assign p1_pin_out = port1_data_latch_ff;
  assign p2_pin_out = port2_data_latch_ff;

  // Driver enables
  assign p0_pin_oe_n = drive_oe_n(port0_data_latch_ff, port0_analog_select,
    port0_drive_type, crossbar_enable_bit);
  assign p1_pin_oe_n = drive_oe_n(port1_data_latch_ff, port1_analog_select_ff,
    port1_drive_type_ff, crossbar_enable_bit);
  assign p2_pin_oe_n = drive_oe_n(port2_data_latch_ff, port2_analog_select_ff,
    p2_drive_full, crossbar_enable_bit);

  // Weak pullups
  assign p0_pullup_en = pullup_on(port0_data_latch_ff, port0_analog_select,
    port0_drive_type, crossbar_enable_bit, weak_pullup_disable);
  assign p1_pullup_en = pullup_on(port1_data_latch_ff, port1_analog_select_ff,
    port1_drive_type_ff, crossbar_enable_bit, weak_pullup_disable);
  assign p2_pullup_en = pullup_on(port2_data_latch_ff, port2_analog_select_ff,
    p2_drive_full, crossbar_enable_bit, weak_pullup_disable);

  // Digital receivers follow the input mode
  assign p0_receiver_en = port0_analog_select;
  assign p1_receiver_en = port1_analog_select_ff;
  assign p2_receiver_en = port2_analog_select_ff;

  // ---------------------------------------------------------------------------
  // Crossbar and overdrive selects
  // ---------------------------------------------------------------------------
  // Skip flags go to the priority decoder as they stand
  assign p0_crossbar_skip = port0_crossbar_bypass_ff;
  assign p1_crossbar_skip = port1_crossbar_bypass_ff;
  assign p2_crossbar_skip = port2_crossbar_bypass_ff;

  // One means high-impedance overdrive
  assign p0_hiz_overdrive = port0_overdrive_select_ff;
endmodule // pim_port_io

// [pim_port_io_monitor.sv]
// Concurrent checks on the pin, match and register ports of the port I/O block
`timescale 1ns/10ps
module pim_port_io_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic crossbar_enable_bit,
  input wire logic port_match_irq_enable,
  input wire logic [7:0] port0_analog_select,
  input wire logic [7:0] port0_drive_type,
  input wire logic [7:0] p0_pin_in,
  input wire logic [7:0] p0_pin_out,
  input wire logic [7:0] p0_pin_oe_n,
  input wire logic [7:0] p1_pin_out,
  input wire logic [7:0] p1_pin_oe_n,
  input wire logic [7:0] p1_pullup_en,
  input wire logic [7:0] p1_receiver_en,
  input wire logic [7:0] p1_crossbar_skip,
  input wire logic [7:0] p0_hiz_overdrive,
  input wire logic port0_match,
  input wire logic port1_match,
  input wire logic port_match_irq,
  input wire logic port_match_wake
);
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  xbar_off_a:
    assert property (!crossbar_enable_bit |-> (&p0_pin_oe_n) && (&p1_pin_oe_n))
    else $error("driver on while crossbar off");
  wake_or_a:
    assert property (port_match_wake == (port0_match | port1_match))
    else $error("wake differs from match events");
  irq_gate_a:
    assert property (port_match_irq == (port_match_wake & port_match_irq_enable))
    else $error("irq not gated by enable");
  analog_off_a:
    assert property ((~p1_receiver_en & (~p1_pin_oe_n | p1_pullup_en)) == 8'h00)
    else $error("analog pin still driven or pulled");
  p0_mode_a:
    assert property (crossbar_enable_bit |-> p0_pin_oe_n ==
      ~(port0_analog_select & (port0_drive_type | ~p0_pin_out)))
    else $error("port 0 driver enable wrong");
  skip_wr_a:
    assert property (sfr_wr && ce && sfr_addr == 8'hD5 |=> p1_crossbar_skip == $past(sfr_wdata))
    else $error("skip flags not written");
  hiz_wr_a:
    assert property (sfr_wr && ce && sfr_addr == 8'hB0 |=> p0_hiz_overdrive == $past(sfr_wdata))
    else $error("overdrive select not written");
  pin_read_a:
    assert property (sfr_rd && ce && !sfr_rmw && sfr_addr == 8'h80 |=>
      sfr_rdata == ($past(p0_pin_in, 3) & $past(port0_analog_select)))
    else $error("port 0 pin read wrong");
  rmw_read_a:
    assert property (sfr_rd && ce && sfr_rmw && sfr_addr == 8'h90 |=>
      sfr_rdata == $past(p1_pin_out))
    else $error("latch read wrong");
  cover property (port0_match && port_match_irq);
  cover property (port1_match);
  cover property (sfr_rd && sfr_rmw);
endmodule // pim_port_io_monitor

bind pim_port_io pim_port_io_monitor u_pim_port_io_monitor (.*);

// [pim_port_io_tb.sv]
// Self-checking bench for the three-port I/O block
`timescale 1ns/10ps
module pim_port_io_tb;
  typedef struct {logic [2:0] sel; logic [7:0] exp;} pim_note_t;
  logic clk, rst_n, ce, sfr_wr, sfr_rd, sfr_rmw, xbar, wpd, irq_en, probe;
  logic [7:0] sfr_addr, sfr_wdata, p0_asel, p0_type, seen, wv;
  logic [7:0] ext_en [3];
  logic [7:0] ext_val [3];
  wire [7:0] sfr_rdata, hiz;
  wire [7:0] pin_in [3], pin_out [3], oe_n [3], pull [3], recv [3], skip [3];
  wire m0, m1, irq, wake;
  pim_note_t exp_q [$];
  pim_note_t note;
  int n_errors = 0;
  int checks = 0;
  logic rd_pend = 1'b0;
  string nm [7] = '{"rdata", "oe_n", "match", "skip", "hiz", "pullup", "oe2_n"};
  logic [7:0] ra [15] = '{8'h80, 8'h90, 8'hA0, 8'hA5, 8'hA6, 8'hB0, 8'hBF, 8'hC7,
                          8'hCF, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hF2, 8'hF3};
  logic [7:0] rv [15] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                          8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};

  pim_port_io u_pim_port_io (.clk(clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .crossbar_enable_bit(xbar), .weak_pullup_disable(wpd),
    .port_match_irq_enable(irq_en), .port0_analog_select(p0_asel),
    .port0_drive_type(p0_type), .p0_pin_in(pin_in[0]), .p0_pin_out(pin_out[0]),
    .p0_pin_oe_n(oe_n[0]), .p1_pin_in(pin_in[1]), .p1_pin_out(pin_out[1]),
    .p1_pin_oe_n(oe_n[1]), .p2_pin_in(pin_in[2]), .p2_pin_out(pin_out[2]),
    .p2_pin_oe_n(oe_n[2]), .p0_pullup_en(pull[0]), .p1_pullup_en(pull[1]),
    .p2_pullup_en(pull[2]), .p0_receiver_en(recv[0]), .p1_receiver_en(recv[1]),
    .p2_receiver_en(recv[2]), .p0_crossbar_skip(skip[0]), .p1_crossbar_skip(skip[1]),
    .p2_crossbar_skip(skip[2]), .p0_hiz_overdrive(hiz), .port0_match(m0),
    .port1_match(m1), .port_match_irq(irq), .port_match_wake(wake));

  // One pad model per port
  for (genvar i = 0; i < 3; i++) begin : g_pad
    pim_pad_model u_pim_pad_model (.clk(clk), .pin_out(pin_out[i]), .pin_oe_n(oe_n[i]),
      .pullup_en(pull[i]), .ext_en(ext_en[i]), .ext_val(ext_val[i]), .pad(pin_in[i]));
  end

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  // One register cycle, strobes held for exactly one edge
  task automatic bus(input logic w, input logic r, input logic m,
                     input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {sfr_wr, sfr_rd, sfr_rmw, sfr_addr, sfr_wdata} = {w, r, m, a, d};
    @(posedge clk);
    #1 {sfr_wr, sfr_rd, sfr_rmw} = 3'b000;
  endtask
  // Read with its expected data noted first
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic m = 1'b0);
    exp_q.push_back('{3'd0, e});
    bus(1'b0, 1'b1, m, a, 8'h00);
  endtask
  // Sample a pin or match output at the second edge
  task automatic obs(input logic [2:0] s, input logic [7:0] e);
    exp_q.push_back('{s, e});
    @(posedge clk);
    #1 probe = 1'b1;
    @(posedge clk);
    #1 probe = 1'b0;
  endtask
  task automatic reset_dut();
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    // Pin synchronisers need two edges before a pin read is valid
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watcher: oldest note against whatever just appeared
  always @(posedge clk) begin
    if (rd_pend || probe) begin
      note = exp_q.pop_front();
      case (note.sel)
        3'd0: seen = sfr_rdata;
        3'd1: seen = oe_n[1];
        3'd2: seen = {4'h0, wake, irq, m1, m0};
        3'd3: seen = skip[1];
        3'd5: seen = pull[1];
        3'd6: seen = oe_n[2];
        default: seen = hiz;
      endcase
      checks++;
      if (seen !== note.exp) begin
        n_errors++;
        $display("BAD %s expected %h seen %h", nm[note.sel], note.exp, seen);
      end
    end
    rd_pend <= sfr_rd & ce;
  end

  // Hang guard
  initial begin
    #50000;
    n_errors++;
    finish_test();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'he21b2c4c));
    {sfr_wr, sfr_rd, sfr_rmw, xbar, wpd, probe, sfr_addr, sfr_wdata} = '0;
    {ce, irq_en, p0_asel, p0_type} = {2'b11, 8'hFF, 8'h00};
    ext_en = '{default: 8'h00};
    ext_val = '{default: 8'h00};
    reset_dut();
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(8'h55, 8'h00);
    // Random write then read back, unmapped address ignored
    for (int i = 3; i < 15; i++) begin
      wv = 8'($urandom);
      bus(1'b1, 1'b0, 1'b0, ra[i], wv);
      rd(ra[i], (ra[i] == 8'hA6) ? (wv & 8'h01) : wv);
    end
    bus(1'b1, 1'b0, 1'b0, 8'h55, 8'h3C);
    rd(8'h55, 8'h00);
    reset_dut();
    // Port 1 drive modes, analog pin with latch left at 1
    xbar = 1'b1;
    bus(1'b1, 1'b0, 1'b0, 8'hA5, 8'h33);
    bus(1'b1, 1'b0, 1'b0, 8'h90, 8'h0F);
    bus(1'b1, 1'b0, 1'b0, 8'hF2, 8'hFE);
    bus(1'b1, 1'b0, 1'b0, 8'hD5, 8'h01);
    obs(3'd3, 8'h01);
    // Write with clock enable low must not land
    ce = 1'b0;
    bus(1'b1, 1'b0, 1'b0, 8'hD5, 8'hFF);
    ce = 1'b1;
    obs(3'd3, 8'h01);
    obs(3'd1, 8'h0D);
    obs(3'd5, 8'h0C);
    wv = 8'($urandom) & 8'h0C;
    ext_en[1] = 8'h0C;
    ext_val[1] = wv;
    repeat (3) @(posedge clk);
    rd(8'h90, 8'h02 | wv);
    rd(8'h90, 8'h0F, 1'b1);
    bus(1'b1, 1'b0, 1'b0, 8'hB0, 8'hA5);
    obs(3'd4, 8'hA5);
    xbar = 1'b0;
    obs(3'd1, 8'hFF);
    xbar = 1'b1;
    // Port 2 drive type: only bit 0 takes a write
    bus(1'b1, 1'b0, 1'b0, 8'hA6, 8'hFF);
    obs(3'd6, 8'hFE);
    // Port 0 match on pin 0, then masked away
    bus(1'b1, 1'b0, 1'b0, 8'hC7, 8'h01);
    bus(1'b1, 1'b0, 1'b0, 8'h80, 8'hFE);
    repeat (2) @(posedge clk);
    obs(3'd2, 8'h0D);
    irq_en = 1'b0;
    obs(3'd2, 8'h09);
    bus(1'b1, 1'b0, 1'b0, 8'hC7, 8'h02);
    obs(3'd2, 8'h00);
    // Port 1 match on pin 7 against both values
    bus(1'b1, 1'b0, 1'b0, 8'hBF, 8'h80);
    for (int b = 0; b < 2; b++) begin
      wv = 8'($urandom);
      bus(1'b1, 1'b0, 1'b0, 8'hCF, {b[0], wv[6:0]});
      obs(3'd2, b ? 8'h0A : 8'h00);
    end
    finish_test();
  end
endmodule // pim_port_io_tb

// [pim_regs.vh]
// Register addresses, field layouts and reset values of the port I/O block
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`ifndef PIM_REGS_VH
`define PIM_REGS_VH

// ---------------------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------------------
`define PIM_ADDR_P0_LATCH 8'h80
`define PIM_ADDR_P1_LATCH 8'h90
`define PIM_ADDR_P2_LATCH 8'hA0
`define PIM_ADDR_P1_DRIVE 8'hA5
`define PIM_ADDR_P2_DRIVE 8'hA6
`define PIM_ADDR_P0_OVRDRV 8'hB0
`define PIM_ADDR_P1_MASK 8'hBF
`define PIM_ADDR_P0_MASK 8'hC7
`define PIM_ADDR_P1_VALUE 8'hCF
`define PIM_ADDR_P0_BYPASS 8'hD4
`define PIM_ADDR_P1_BYPASS 8'hD5
`define PIM_ADDR_P2_BYPASS 8'hD6
`define PIM_ADDR_P0_VALUE 8'hD7
`define PIM_ADDR_P1_ANALOG 8'hF2
`define PIM_ADDR_P2_ANALOG 8'hF3

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define PIM_RST_LATCH 8'hFF
`define PIM_RST_DRIVE 8'h00
`define PIM_RST_OVRDRV 8'h00
`define PIM_RST_MASK 8'h00
`define PIM_RST_VALUE 8'hFF
`define PIM_RST_BYPASS 8'h00
`define PIM_RST_ANALOG 8'hFF
`define PIM_RST_RDATA 8'h00

// ---------------------------------------------------------------------------
// Field layouts
// ---------------------------------------------------------------------------
`define PIM_P2_DRIVE_WR_BIT 0
`define PIM_P2_DRIVE_RO_MSB 7
`define PIM_P2_DRIVE_RO_LSB 1
`define PIM_UNMAPPED_READ 8'h00

`endif
